// File: hdl/eeprom_status_and_write_protect.sv
// Status commands and write-protection core of the serial memory
`timescale 1ns/100ps
`default_nettype none
module eeprom_status_and_write_protect
  import prot_pkg::*;
#(
  parameter int write_cycles = write_cycles_default
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic engine_busy,
  input wire logic array_wr_req,
  input wire logic [17:0] array_wr_addr,
  output logic so,
  output logic so_oe,
  output logic array_wr_grant,
  output logic array_wr_deny,
  output logic [7:0] protection_status,
  output logic ready_busy_flag
);
  localparam logic [timer_width-1:0] timer_last = timer_width'(write_cycles - 1);
  localparam logic [timer_width-1:0] timer_step = timer_width'(1);

  link_if lk ();

  logic [1:0] pin_s;
  logic sel_s;
  logic wp_low;
  logic sel_q;
  logic frame_end;
  logic opcode_frame;
  logic write_frame;
  logic hw_protect;
  logic busy;
  logic engine_q;
  logic engine_done;
  logic sr_done;
  logic sr_accept;
  logic cycle_end;
  logic array_ok;
  logic pen;
  logic [1:0] bp;
  logic write_enable_latch;
  core_state_type state;
  logic [timer_width-1:0] timer;

  // ==========================================================
  // Link side
  spi_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .rst_n(rst_n),
    .so(so),
    .so_oe(so_oe),
    .lk(lk.link_side)
  );

  assign lk.pen = pen;
  assign lk.bp = bp;
  assign lk.write_enable_latch = write_enable_latch;
  assign lk.busy = ready_busy_flag;

  // ==========================================================
  // Pin synchronisers and frame end
  bit_sync #(.width(2)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~cs_n, ~wp_n}),
    .q(pin_s)
  );

  // Active-high copies, so the reset value matches an idle deselected link
  assign sel_s = pin_s[1];
  assign wp_low = pin_s[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_q <= 1'b0;
    end else begin
      engine_q <= engine_busy;
    end
  end

  // ==========================================================
  // Command decode
  assign frame_end = sel_q && !sel_s;
  assign opcode_frame = frame_end && !lk.over && (lk.count == opcode_bits);
  assign write_frame = frame_end && !lk.over && (lk.count == status_write_bits)
                       && (lk.opcode == status_write_cmd);
  assign hw_protect = pen && wp_low;
  assign busy = (state == st_sr_write) || engine_busy;
  assign sr_accept = write_frame && !busy && write_enable_latch && !hw_protect;
  assign sr_done = (state == st_sr_write) && (timer == timer_last);
  assign engine_done = engine_q && !engine_busy;
  assign cycle_end = sr_done || engine_done;

  // ==========================================================
  // Self-timed status write cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (sr_accept) begin
            state <= st_sr_write;
          end
        end
        st_sr_write: begin
          if (sr_done) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= '0;
    end else if (state == st_sr_write) begin
      timer <= timer_width'(timer + timer_step);
    end else begin
      timer <= '0;
    end
  end

  // ==========================================================
  // Protect bits, kept at factory default until written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pen <= nv_pen_default;
      bp <= nv_bp_default;
    end else if (sr_accept) begin
      pen <= lk.data[pos_pen];
      bp <= {lk.data[pos_bp_hi], lk.data[pos_bp_lo]};
    end
  end

  // ==========================================================
  // Write enable latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (opcode_frame && !busy && lk.opcode == latch_set_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (cycle_end) begin
      write_enable_latch <= 1'b0;
    end else if (opcode_frame && !busy && lk.opcode == latch_clear_cmd) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================
  // Array write gate
  assign array_ok = write_enable_latch && !busy && !block_protected(bp, array_wr_addr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      array_wr_grant <= 1'b0;
      array_wr_deny <= 1'b0;
    end else begin
      array_wr_grant <= array_wr_req && array_ok;
      array_wr_deny <= array_wr_req && !array_ok;
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protection_status <= '0;
      ready_busy_flag <= 1'b0;
    end else begin
      protection_status <= status_byte(pen, bp, write_enable_latch, busy);
      ready_busy_flag <= busy;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  chk_latch_set_cmd: assert property (
    opcode_frame && !busy && lk.opcode == latch_set_cmd |=> write_enable_latch ##1 protection_status[1]
  ) else $error("latch set command did not set the latch");

  chk_latch_clear_cmd: assert property (
    opcode_frame && !busy && lk.opcode == latch_clear_cmd |=> !write_enable_latch
  ) else $error("latch clear command did not clear the latch");

  chk_odd_count_keep: assert property (
    frame_end && !opcode_frame && !cycle_end |=> $stable(write_enable_latch)
  ) else $error("latch changed on a frame that was not eight bits");

  chk_busy_ignores_cmds: assert property (
    frame_end && busy && !cycle_end |=> $stable(write_enable_latch) && $stable(pen) && $stable(bp)
  ) else $error("command acted during a write cycle");

  chk_hw_refuse_write: assert property (
    write_frame && hw_protect |=> $stable(pen) && $stable(bp) && $stable(state)
  ) else $error("status write passed under hardware protection");

  chk_pen_stays_set: assert property (
    pen && wp_low |=> pen
  ) else $error("pin enable cleared while pin held low");

  chk_no_latch_refuse: assert property (
    write_frame && !write_enable_latch && !busy |=> state == st_idle && $stable(pen) && $stable(bp)
  ) else $error("status write accepted without the latch");

  chk_write_takes_bits: assert property (
    sr_accept |=> pen == $past(lk.data[pos_pen]) && state == st_sr_write
  ) else $error("status write did not take the enable bit");

  chk_busy_status_bits: assert property (
    sr_accept |=> ##1 protection_status[pos_busy] && protection_status[6:4] == reserved_busy
  ) else $error("busy not shown in status bits");

  chk_end_clears_latch: assert property (
    $fell(state == st_sr_write) |-> !write_enable_latch
  ) else $error("latch still set after status write cycle");

  chk_array_gate_deny: assert property (
    array_wr_req && (!write_enable_latch || block_protected(bp, array_wr_addr)) |=> array_wr_deny && !array_wr_grant
  ) else $error("array write granted without permission");

  cov_status_write: cover property (sr_accept ##1 state == st_sr_write);
  cov_latch_set: cover property (opcode_frame && lk.opcode == latch_set_cmd && !busy);
  cov_hw_refuse: cover property (write_frame && hw_protect);
  cov_array_grant: cover property (array_wr_grant);
endmodule
`default_nettype wire

// File: shared/prot_pkg.sv
// Constants, types and helpers for the status and write-protect block
`default_nettype none
package prot_pkg;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] low_power_poll_cmd = 8'h08;
  localparam logic [7:0] latch_set_cmd = 8'h06;
  localparam logic [7:0] latch_clear_cmd = 8'h04;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] opcode_bits = 8'h08;
  localparam logic [7:0] status_write_bits = 8'h10;
  localparam logic [7:0] opcode_last_bit = 8'h07;
  localparam logic [7:0] data_last_bit = 8'h0F;
  localparam logic [7:0] count_last = 8'hFF;
  localparam logic [2:0] byte_phase_zero = 3'h0;
  localparam logic [7:0] poll_busy_byte = 8'hFF;
  localparam logic [7:0] poll_ready_byte = 8'h00;
  localparam logic [2:0] reserved_busy = 3'h7;
  localparam logic [2:0] reserved_idle = 3'h0;
  localparam int pos_pen = 7;
  localparam int pos_bp_hi = 3;
  localparam int pos_bp_lo = 2;
  localparam int pos_busy = 0;
  localparam logic nv_pen_default = 1'h0;
  localparam logic [1:0] nv_bp_default = 2'h0;
  localparam logic [1:0] bp_none = 2'h0;
  localparam logic [1:0] bp_quarter = 2'h1;
  localparam logic [1:0] bp_half = 2'h2;
  localparam logic [17:0] quarter_base = 18'h3_0000;
  localparam logic [17:0] half_base = 18'h2_0000;
  localparam int clk_period_ns = 10;
  localparam int write_time_ns = 5_000_000;
  localparam int write_cycles_default = write_time_ns / clk_period_ns;
  localparam int timer_width = 24;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_sr_write = 2'b10
  } core_state_type;

  // Array range guarded by the block level
  function automatic logic block_protected(input logic [1:0] bp, input logic [17:0] addr);
    unique case (bp)
      bp_none: block_protected = 1'b0;
      bp_quarter: block_protected = (addr >= quarter_base);
      bp_half: block_protected = (addr >= half_base);
      default: block_protected = 1'b1;
    endcase
  endfunction

  // Status byte layout
  function automatic logic [7:0] status_byte(input logic pen, input logic [1:0] bp,
                                             input logic write_enable_latch, input logic busy);
    status_byte = {pen, busy ? reserved_busy : reserved_idle, bp, write_enable_latch, busy};
  endfunction
endpackage
`default_nettype wire

// File: shared/link_if.sv
// Carrier between the serial link logic and the protection core
`timescale 1ns/100ps
`default_nettype none
interface link_if;
  logic [7:0] opcode;
  logic [7:0] data;
  logic [7:0] count;
  logic over;
  logic pen;
  logic [1:0] bp;
  logic write_enable_latch;
  logic busy;
  modport link_side (output opcode, data, count, over, input pen, bp, write_enable_latch, busy);
  modport core_side (input opcode, data, count, over, output pen, bp, write_enable_latch, busy);
endinterface
`default_nettype wire

// File: hdl/bit_sync.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: hdl/spi_link.sv
// Serial link logic on the link clock
`timescale 1ns/100ps
`default_nettype none
module spi_link
  import prot_pkg::*;
(
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rst_n,
  output logic so,
  output logic so_oe,
  link_if.link_side lk
);
  logic in_frame;
  logic [7:0] bits_before;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [4:0] st_s;
  logic reading;
  logic boundary;
  logic [7:0] out_byte;

  bit_sync #(.width(5)) u_state_sync (
    .clk(sck),
    .rst_n(rst_n),
    .d({lk.pen, lk.bp, lk.write_enable_latch, lk.busy}),
    .q(st_s)
  );

  // ==========================================================
  // Frame and input shift
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= 1'b0;
    end else if (cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  assign bits_before = in_frame ? lk.count : '0;

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk.count <= '0;
      lk.over <= 1'b0;
      rx <= '0;
      lk.opcode <= '0;
      lk.data <= '0;
    end else begin
      lk.count <= 8'(bits_before + 8'h01);
      lk.over <= in_frame && (lk.over || lk.count == count_last);
      rx <= {rx[6:0], si};
      if (bits_before == opcode_last_bit) begin
        lk.opcode <= {rx[6:0], si};
      end
      if (bits_before == data_last_bit) begin
        lk.data <= {rx[6:0], si};
      end
    end
  end

  // ==========================================================
  // Output shift
  assign reading = in_frame && (lk.opcode == status_read_cmd || lk.opcode == low_power_poll_cmd)
                   && (lk.over || lk.count >= opcode_bits);
  assign boundary = (lk.count[2:0] == byte_phase_zero);
  assign out_byte = (lk.opcode == low_power_poll_cmd) ?
                    (st_s[0] ? poll_busy_byte : poll_ready_byte) :
                    status_byte(st_s[4], st_s[3:2], st_s[1], st_s[0]);

  always_ff @(negedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      tx <= '0;
    end else if (cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      tx <= '0;
    end else if (reading) begin
      so_oe <= 1'b1;
      if (boundary) begin
        so <= out_byte[7];
        tx <= {out_byte[6:0], 1'b0};
      end else begin
        so <= tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end else begin
      so_oe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: test/spi_master_model.sv
// Serial link master model driving frames into the device
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // ==========
  // Idle levels
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ==========
  // One frame, mode 0, clock only inside the frame
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      si = tx[i];
      #24 sck = 1'b1;
      rx = {rx[30:0], so};
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    si = ~si;
    #120;
  endtask
endmodule
`default_nettype wire

// File: test/test_eeprom_status_and_write_protect.sv
// Testbench for the status and write-protect block
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_status_and_write_protect;
  import prot_pkg::*;
  typedef struct packed {
    logic eb;
    logic wp;
    logic [15:0] tx;
    logic [7:0] nb;
    logic [7:0] st;
    logic [17:0] addr;
  } row_type;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic engine_busy = 1'b0;
  logic array_wr_req = 1'b0;
  logic [17:0] array_wr_addr = 18'h0_0000;
  wire logic sck, cs_n, si, so, so_oe, array_wr_grant, array_wr_deny, ready_busy_flag;
  wire logic [7:0] protection_status;
  logic [31:0] rx;
  int mismatches = 0;
  int n_compared = 0;
  // Fields: engine busy, pin, frame, bit count, status, array address
  row_type rows [20] = '{
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h02, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0004, 8'h08, 8'h00, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0003, 8'h07, 8'h00, 18'h0_0000},
    '{1'b0, 1'b1, 16'h000C, 8'h09, 8'h00, 18'h0_0000},
    '{1'b0, 1'b1, 16'h01FF, 8'h10, 8'h00, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h02, 18'h0_0000},
    '{1'b0, 1'b1, 16'h01FF, 8'h10, 8'h8C, 18'h0_0000},
    '{1'b0, 1'b0, 16'h0006, 8'h08, 8'h8E, 18'h0_0000},
    '{1'b0, 1'b0, 16'h0100, 8'h10, 8'h8E, 18'h0_0000},
    '{1'b0, 1'b0, 16'h0004, 8'h08, 8'h8C, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h8E, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0104, 8'h10, 8'h04, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h06, 18'h2_FFFF},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h06, 18'h3_0000},
    '{1'b0, 1'b1, 16'h0108, 8'h10, 8'h08, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h0A, 18'h1_FFFF},
    '{1'b0, 1'b1, 16'h0006, 8'h08, 8'h0A, 18'h2_0000},
    '{1'b0, 1'b1, 16'h0004, 8'h08, 8'h08, 18'h0_0000},
    '{1'b1, 1'b1, 16'h0006, 8'h08, 8'h79, 18'h0_0000},
    '{1'b0, 1'b1, 16'h0005, 8'h08, 8'h08, 18'h0_0000}
  };

  always #5 clk = ~clk;

  eeprom_status_and_write_protect #(.write_cycles(100)) uut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .engine_busy(engine_busy), .array_wr_req(array_wr_req), .array_wr_addr(array_wr_addr),
    .so(so), .so_oe(so_oe), .array_wr_grant(array_wr_grant), .array_wr_deny(array_wr_deny),
    .protection_status(protection_status), .ready_busy_flag(ready_busy_flag)
  );

  spi_master_model m (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

  // ==========
  // Helpers
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic exp_grant(input logic [7:0] st, input logic [17:0] a);
    logic p;
    case (st[3:2])
      2'h0: p = 1'b0;
      2'h1: p = (a >= 18'h3_0000);
      2'h2: p = (a >= 18'h2_0000);
      default: p = 1'b1;
    endcase
    return st[1] & ~st[0] & ~p;
  endfunction

  task automatic gate(input logic [17:0] a, input logic g);
    @(posedge clk);
    array_wr_req <= 1'b1;
    array_wr_addr <= a;
    @(posedge clk);
    array_wr_req <= 1'b0;
    @(negedge clk);
    check("grant", {7'h0, array_wr_grant}, {7'h0, g});
    check("deny", {7'h0, array_wr_deny}, {7'h0, ~g});
  endtask

  task automatic rd_refresh(input logic [7:0] op, input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk);
    engine_busy <= 1'b1;
    repeat (5) @(posedge clk);
    fork
      m.xfer({8'h0, op, 16'h0}, 24, rx);
      begin
        #550;
        @(posedge clk);
        engine_busy <= 1'b0;
      end
    join
    check("first byte", rx[15:8], e1);
    check("second byte", rx[7:0], e2);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========
  // Watchdog
  initial begin
    #400_000;
    mismatches++;
    stop_test();
  end

  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("status after reset", protection_status, 8'h00);
    check("output enable", {7'h0, so_oe}, 8'h00);
    $display("reset test done");
    repeat (5) @(posedge clk);
    foreach (rows[i]) begin
      @(posedge clk);
      wp_n <= rows[i].wp;
      engine_busy <= rows[i].eb;
      repeat (3) @(posedge clk);
      m.xfer({16'h0, rows[i].tx}, int'(rows[i].nb), rx);
      repeat (130) @(posedge clk);
      @(negedge clk);
      check("status", protection_status, rows[i].st);
      check("busy flag", {7'h0, ready_busy_flag}, {7'h0, rows[i].st[0]});
      gate(rows[i].addr, exp_grant(rows[i].st, rows[i].addr));
      $display("row %0d done", i);
    end
    m.xfer(32'h0000_0006, 8, rx);
    rd_refresh(status_read_cmd, 8'h7B, 8'h08);
    rd_refresh(low_power_poll_cmd, 8'hFF, 8'h00);
    $display("continuous read test done");
    m.xfer(32'h0000_0006, 8, rx);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("status after second reset", protection_status, 8'h00);
    $display("second reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
